// >>> wide_store_pkg.sv
// Constants and types for the 16-bit register transfer and store decoder
package wide_store_pkg;
	// Core clock and instruction cycle
	localparam int unsigned CLOCK_HZ         = 10_000_000;
	localparam int unsigned CLOCKS_PER_CYCLE = 2;
	localparam logic [0:0]  DIV_LAST         = 1'(CLOCKS_PER_CYCLE - 1);

	// Opcodes
	localparam logic [7:0] OPC_PREFIX     = 8'hcf;
	localparam logic [7:0] OPC_IY_FROM_SP = 8'hfe;
	localparam logic [7:0] OPC_SP_FROM_RP = 8'hf0;
	localparam logic [7:0] OPC_ST_ABS     = 8'hbc;
	localparam logic [7:0] OPC_ST_SP_ABS  = 8'h78;
	localparam logic [7:0] OPC_ST_HL      = 8'hd8;
	localparam logic [7:0] OPC_ST_IX      = 8'hd4;
	localparam logic [7:0] OPC_ST_IY      = 8'hdc;
	localparam logic [7:0] OPC_ST_SPD     = 8'h74;

	// Instruction lengths in bytes and in instruction cycles
	localparam logic [2:0] LEN_REG     = 3'h2;
	localparam logic [2:0] LEN_ABS     = 3'h3;
	localparam logic [2:0] LEN_SP_ABS  = 3'h4;
	localparam logic [2:0] LEN_IND     = 3'h2;
	localparam logic [2:0] LEN_SPD     = 3'h3;
	localparam logic [2:0] CYC_REG     = 3'h2;
	localparam logic [2:0] CYC_ABS     = 3'h5;
	localparam logic [2:0] CYC_SP_ABS  = 3'h6;
	localparam logic [2:0] CYC_IND     = 3'h5;
	localparam logic [2:0] CYC_SPD     = 3'h6;

	// Register preset selects
	localparam logic [3:0] SEL_SP    = 4'h4;
	localparam logic [3:0] SEL_EP    = 4'h5;
	localparam logic [3:0] SEL_XP    = 4'h6;
	localparam logic [3:0] SEL_YP    = 4'h7;
	localparam logic [3:0] SEL_FLAGS = 4'h8;

	// Reset values and the fixed page of stack-relative stores
	localparam logic [15:0] PAIR_RESET = 16'h0000;
	localparam logic [7:0]  PAGE_RESET = 8'h00;
	localparam logic [7:0]  STACK_PAGE = 8'h00;
	localparam logic [7:0]  FLAGS_RESET = 8'h00;

	typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EXEC} state_t;

	typedef enum logic [3:0] {
		K_NONE, K_IY_SP, K_SP_RP, K_ST_ABS, K_ST_SP_ABS,
		K_ST_HL, K_ST_IX, K_ST_IY, K_ST_SPD
	} kind_t;
endpackage

// >>> wide_register_load_store.sv
// Decoder and sequencer for 16-bit register transfers and stores
`timescale 1ns/1ps
module wide_register_load_store
	import wide_store_pkg::*;
(
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// Memory model strap pin
	input  wire logic        LARGE_MODEL,
	// Instruction byte stream
	input  wire logic        OP_VALID,
	input  wire logic [7:0]  OP_BYTE,
	output logic             OP_READY,
	// Data memory write port
	output logic             MEM_WR,
	output logic [23:0]      MEM_ADDR,
	output logic [7:0]       MEM_WDATA,
	// Register preset from the rest of the core
	input  wire logic        PRESET_WR,
	input  wire logic [3:0]  PRESET_SEL,
	input  wire logic [15:0] PRESET_DATA,
	// Register state
	output logic [15:0]      PAIR_BA,
	output logic [15:0]      POINTER_PAIR,
	output logic [15:0]      FIRST_INDEX_REG,
	output logic [15:0]      SECOND_INDEX_REG,
	output logic [15:0]      STACK_TOP_POINTER,
	output logic [7:0]       EXPAND_PAGE_REG,
	output logic [7:0]       FIRST_INDEX_PAGE_REG,
	output logic [7:0]       SECOND_INDEX_PAGE_REG,
	output logic [7:0]       SYSTEM_CONDITION_FLAGS,
	// Status
	output logic             BUSY,
	output logic             DONE,
	output logic             ILLEGAL
);

	logic [0:0]  div_q;
	logic        tick;
	logic        model_meta_q;
	logic        model_q;
	state_t      state_q;
	kind_t       kind_q;
	kind_t       kind_d;
	logic        prefix_q;
	logic [1:0]  pair_sel_q;
	logic [2:0]  cyc_q;
	logic [2:0]  cyc_next;
	logic [2:0]  len_q;
	logic [2:0]  total_q;
	logic [2:0]  len_d;
	logic [2:0]  total_d;
	logic [15:0] operand_q;
	logic [15:0] pair_q [4];
	logic [15:0] sp_q;
	logic [7:0]  ep_q;
	logic [7:0]  xp_q;
	logic [7:0]  yp_q;
	logic [7:0]  flags_q;
	logic [15:0] base_addr;
	logic [15:0] src_data;
	logic [7:0]  page;
	logic [23:0] addr_lo_q;
	logic [15:0] data_q;
	logic        take;
	logic        decode_now;
	logic        reg_exec;

	// Instruction cycle is two core clocks
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			div_q <= '0;
		else
			div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
	end
	assign tick = (div_q == DIV_LAST);

	// Strap pin is asynchronous to the core
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			model_meta_q <= 1'b0;
			model_q      <= 1'b0;
		end else begin
			model_meta_q <= LARGE_MODEL;
			model_q      <= model_meta_q;
		end
	end

	assign OP_READY   = tick && (state_q != S_EXEC);
	assign take       = OP_READY && OP_VALID;
	assign cyc_next   = cyc_q + 3'h1;
	assign decode_now = take && (state_q == S_FETCH) && (cyc_q == 3'h1) && prefix_q;

	// Opcode decode, both for a plain first byte and after the prefix
	always_comb begin
		kind_d  = K_NONE;
		len_d   = LEN_REG;
		total_d = CYC_REG;
		if (state_q == S_IDLE) begin
			if ({OP_BYTE[7:2], 2'b00} == OPC_ST_ABS) begin
				kind_d  = K_ST_ABS;
				len_d   = LEN_ABS;
				total_d = CYC_ABS;
			end
		end else if (OP_BYTE == OPC_IY_FROM_SP) begin
			kind_d = K_IY_SP;
		end else if ({OP_BYTE[7:2], 2'b00} == OPC_SP_FROM_RP) begin
			kind_d = K_SP_RP;
		end else if (OP_BYTE == OPC_ST_SP_ABS) begin
			kind_d  = K_ST_SP_ABS;
			len_d   = LEN_SP_ABS;
			total_d = CYC_SP_ABS;
		end else if ({OP_BYTE[7:2], 2'b00} == OPC_ST_HL) begin
			kind_d  = K_ST_HL;
			len_d   = LEN_IND;
			total_d = CYC_IND;
		end else if ({OP_BYTE[7:2], 2'b00} == OPC_ST_IX) begin
			kind_d  = K_ST_IX;
			len_d   = LEN_IND;
			total_d = CYC_IND;
		end else if ({OP_BYTE[7:2], 2'b00} == OPC_ST_IY) begin
			kind_d  = K_ST_IY;
			len_d   = LEN_IND;
			total_d = CYC_IND;
		end else if ({OP_BYTE[7:2], 2'b00} == OPC_ST_SPD) begin
			kind_d  = K_ST_SPD;
			len_d   = LEN_SPD;
			total_d = CYC_SPD;
		end
	end

	// Register-to-register transfers finish on their second byte
	assign reg_exec = decode_now && (kind_d == K_IY_SP || kind_d == K_SP_RP);

	// Sequencer
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q    <= S_IDLE;
			kind_q     <= K_NONE;
			prefix_q   <= 1'b0;
			pair_sel_q <= 2'b00;
			cyc_q      <= 3'h0;
			len_q      <= 3'h0;
			total_q    <= 3'h0;
			operand_q  <= 16'h0000;
		end else if (take || (tick && state_q == S_EXEC)) begin
			cyc_q <= cyc_next;
			unique case (state_q)
				S_IDLE: begin
					cyc_q      <= 3'h1;
					prefix_q   <= (OP_BYTE == OPC_PREFIX);
					pair_sel_q <= OP_BYTE[1:0];
					kind_q     <= kind_d;
					len_q      <= len_d;
					total_q    <= total_d;
					if (OP_BYTE == OPC_PREFIX || kind_d != K_NONE)
						state_q <= S_FETCH;
				end
				S_FETCH: begin
					if (decode_now) begin
						pair_sel_q <= OP_BYTE[1:0];
						kind_q     <= kind_d;
						len_q      <= len_d;
						total_q    <= total_d;
						if (kind_d == K_NONE || reg_exec)
							state_q <= S_IDLE;
						else if (cyc_next == len_d)
							state_q <= S_EXEC;
					end else begin
						// Low byte arrives first, high byte shifts it down
						operand_q <= {OP_BYTE, operand_q[15:8]};
						if (cyc_next == len_q)
							state_q <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (cyc_next == total_q)
						state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Effective address and page for the store kinds
	always_comb begin
		page      = PAGE_RESET;
		base_addr = operand_q;
		unique case (kind_q)
			K_ST_ABS, K_ST_SP_ABS: page = ep_q;
			K_ST_HL: begin
				page      = ep_q;
				base_addr = pair_q[1];
			end
			K_ST_IX: begin
				page      = xp_q;
				base_addr = pair_q[2];
			end
			K_ST_IY: begin
				page      = yp_q;
				base_addr = pair_q[3];
			end
			K_ST_SPD: begin
				// Displacement sits in the upper half after one shift
				page      = STACK_PAGE;
				base_addr = sp_q + {{8{operand_q[15]}}, operand_q[15:8]};
			end
			default: ;
		endcase
		if (!model_q)
			page = PAGE_RESET;
		src_data = (kind_q == K_ST_SP_ABS) ? sp_q : pair_q[pair_sel_q];
	end

	// Memory writes on the last two instruction cycles
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			MEM_WR    <= 1'b0;
			MEM_ADDR  <= 24'h000000;
			MEM_WDATA <= 8'h00;
			addr_lo_q <= 24'h000000;
			data_q    <= 16'h0000;
			DONE      <= 1'b0;
			ILLEGAL   <= 1'b0;
		end else begin
			MEM_WR  <= 1'b0;
			DONE    <= 1'b0;
			ILLEGAL <= 1'b0;
			if (take && state_q == S_IDLE && OP_BYTE != OPC_PREFIX && kind_d == K_NONE)
				ILLEGAL <= 1'b1;
			if (decode_now && kind_d == K_NONE)
				ILLEGAL <= 1'b1;
			if (reg_exec)
				DONE <= 1'b1;
			if (tick && state_q == S_EXEC) begin
				if (cyc_next == total_q - 3'h1) begin
					// Latch the whole word so the high byte matches the low one
					MEM_WR    <= 1'b1;
					MEM_ADDR  <= {page, base_addr};
					MEM_WDATA <= src_data[7:0];
					addr_lo_q <= {page, base_addr};
					data_q    <= src_data;
				end else if (cyc_next == total_q) begin
					MEM_WR    <= 1'b1;
					MEM_ADDR  <= {addr_lo_q[23:16], addr_lo_q[15:0] + 16'h0001};
					MEM_WDATA <= data_q[15:8];
					DONE      <= 1'b1;
				end
			end
		end
	end

	// Register pairs; preset only while idle so an instruction never races it
	for (genvar i = 0; i < 4; i++) begin : g_pair
		always_ff @(posedge CLOCK or negedge RST_N) begin
			if (!RST_N)
				pair_q[i] <= PAIR_RESET;
			else if (reg_exec && kind_d == K_IY_SP && i == 3)
				pair_q[i] <= sp_q;
			else if (PRESET_WR && state_q == S_IDLE && PRESET_SEL == 4'(i))
				pair_q[i] <= PRESET_DATA;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			sp_q <= PAIR_RESET;
		else if (reg_exec && kind_d == K_SP_RP)
			sp_q <= pair_q[OP_BYTE[1:0]];
		else if (PRESET_WR && state_q == S_IDLE && PRESET_SEL == SEL_SP)
			sp_q <= PRESET_DATA;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ep_q    <= PAGE_RESET;
			xp_q    <= PAGE_RESET;
			yp_q    <= PAGE_RESET;
			flags_q <= FLAGS_RESET;
		end else if (PRESET_WR && state_q == S_IDLE) begin
			// Flags change only through preset, never by these instructions
			if (PRESET_SEL == SEL_EP)
				ep_q <= PRESET_DATA[7:0];
			if (PRESET_SEL == SEL_XP)
				xp_q <= PRESET_DATA[7:0];
			if (PRESET_SEL == SEL_YP)
				yp_q <= PRESET_DATA[7:0];
			if (PRESET_SEL == SEL_FLAGS)
				flags_q <= PRESET_DATA[7:0];
		end
	end

	assign PAIR_BA                = pair_q[0];
	assign POINTER_PAIR           = pair_q[1];
	assign FIRST_INDEX_REG        = pair_q[2];
	assign SECOND_INDEX_REG       = pair_q[3];
	assign STACK_TOP_POINTER      = sp_q;
	assign EXPAND_PAGE_REG        = ep_q;
	assign FIRST_INDEX_PAGE_REG   = xp_q;
	assign SECOND_INDEX_PAGE_REG  = yp_q;
	assign SYSTEM_CONDITION_FLAGS = flags_q;
	assign BUSY                   = (state_q != S_IDLE);

endmodule // wide_register_load_store

// >>> wide_store_checker.sv
// Port assertions for the 16-bit transfer and store decoder
`timescale 1ns/1ps
module wide_store_checker (
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RST_N,
	// Inputs watched
	input wire logic        LARGE_MODEL,
	input wire logic        PRESET_WR,
	// Outputs watched
	input wire logic        OP_READY,
	input wire logic        MEM_WR,
	input wire logic [23:0] MEM_ADDR,
	input wire logic [7:0]  SYSTEM_CONDITION_FLAGS,
	input wire logic [15:0] SECOND_INDEX_REG,
	input wire logic [15:0] STACK_TOP_POINTER,
	input wire logic        BUSY,
	input wire logic        DONE
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	store_pair_a: assert property (MEM_WR && !DONE |=> !MEM_WR ##1 (MEM_WR && DONE
		&& MEM_ADDR == {$past(MEM_ADDR[23:16], 2), $past(MEM_ADDR[15:0], 2) + 16'h0001}))
		else $error("high byte not written to the next address");
	done_pulse_a: assert property (DONE |=> !DONE)
		else $error("done longer than one clock");
	flags_hold_a: assert property (!PRESET_WR |=> $stable(SYSTEM_CONDITION_FLAGS))
		else $error("flags changed by an instruction");
	small_page_a: assert property ($past(!LARGE_MODEL, 4) && !LARGE_MODEL && MEM_WR
		|-> MEM_ADDR[23:16] == 8'h00)
		else $error("page used in the small model");
	iy_copy_a: assert property (DONE && $changed(SECOND_INDEX_REG)
		|-> SECOND_INDEX_REG == STACK_TOP_POINTER)
		else $error("second index not loaded from stack pointer");
	done_idle_a: assert property (DONE |-> !BUSY)
		else $error("busy still high at done");
	write_busy_a: assert property (MEM_WR && !DONE |-> BUSY)
		else $error("write outside an instruction");
	write_fetch_a: assert property (MEM_WR |-> !OP_READY)
		else $error("byte offered during a write");
	cover property (MEM_WR && DONE);
	cover property (DONE && $changed(SECOND_INDEX_REG));
	cover property (!LARGE_MODEL && MEM_WR);
endmodule // wide_store_checker

bind wide_register_load_store wide_store_checker i_chk (.CLOCK, .RST_N, .LARGE_MODEL,
	.PRESET_WR, .OP_READY, .MEM_WR, .MEM_ADDR, .SYSTEM_CONDITION_FLAGS, .SECOND_INDEX_REG,
	.STACK_TOP_POINTER, .BUSY, .DONE);

// >>> data_mem_model.sv
// Byte-wide data memory that takes every write pulse
`timescale 1ns/1ps
module data_mem_model (
	// Clock
	input wire logic        clk,
	// Write port
	input wire logic        wr,
	input wire logic [23:0] addr,
	input wire logic [7:0]  wdata
);
	logic [7:0] mem [logic [23:0]];
	int         wr_count = 0;
	// No handshake exists, so a pulse that is missed here is lost for good
	always @(posedge clk) begin
		if (wr === 1'b1) begin
			mem[addr] = wdata;
			wr_count++;
		end
	end
endmodule // data_mem_model

// >>> tb_wide_register_load_store.sv
// Self-checking bench for the 16-bit transfer and store decoder
`timescale 1ns/1ps
module tb_wide_register_load_store;
	import wide_store_pkg::*;
	logic        CLOCK = 1'b0, RST_N = 1'b0, LARGE_MODEL = 1'b1, OP_VALID = 1'b0;
	logic        PRESET_WR = 1'b0, OP_READY, MEM_WR, BUSY, DONE, ILLEGAL, fin, ill;
	logic [3:0]  PRESET_SEL = 4'h0;
	logic [7:0]  OP_BYTE = 8'h00, MEM_WDATA, EXPAND_PAGE_REG, FIRST_INDEX_PAGE_REG;
	logic [7:0]  SECOND_INDEX_PAGE_REG, SYSTEM_CONDITION_FLAGS;
	logic [15:0] PRESET_DATA = 16'h0000, PAIR_BA, POINTER_PAIR, FIRST_INDEX_REG;
	logic [15:0] SECOND_INDEX_REG, STACK_TOP_POINTER;
	logic [15:0] pv [4] = '{16'he964, 16'h2000, 16'h3000, 16'h4000};
	logic [23:0] MEM_ADDR;
	int          num_errors = 0, compares = 0, cyc = 0, took;
	wide_register_load_store i_dut (.*);
	data_mem_model i_mem (.clk(CLOCK), .wr(MEM_WR), .addr(MEM_ADDR), .wdata(MEM_WDATA));
	always #50 CLOCK = ~CLOCK;
	always @(posedge CLOCK) cyc <= cyc + 1;
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic preset(input logic [3:0] sel, input logic [15:0] d);
		@(negedge CLOCK);
		PRESET_WR = 1'b1;
		PRESET_SEL = sel;
		PRESET_DATA = d;
		@(negedge CLOCK);
		PRESET_WR = 1'b0;
	endtask
	// Offers nb bytes, each held until a tick takes it, then waits for the end
	task automatic exec(input logic [31:0] b, input int nb);
		int t0;
		int k;
		for (int i = 0; i < nb; i++) begin
			@(negedge CLOCK);
			OP_VALID = 1'b1;
			OP_BYTE = b[31-8*i -: 8];
			for (k = 0; k < 20 && OP_READY !== 1'b1; k++) @(negedge CLOCK);
			@(posedge CLOCK);
			if (i == 0) t0 = cyc;
		end
		@(negedge CLOCK);
		OP_VALID = 1'b0;
		for (k = 0; k < 20 && DONE !== 1'b1 && ILLEGAL !== 1'b1; k++) @(negedge CLOCK);
		took = cyc - t0;
		fin = DONE;
		ill = ILLEGAL;
	endtask
	// Store of n cycles: low byte at a, high byte at a+1 within the same page
	task automatic st(input logic [31:0] b, input int nb, input int n, input logic [23:0] a,
		input logic [15:0] d);
		int w;
		w = i_mem.wr_count;
		exec(b, nb);
		// The high byte pulse stands with DONE and lands at the next edge
		@(negedge CLOCK);
		check(24'(took), 24'(2 * n - 1));
		check(24'(i_mem.wr_count - w), 24'h000002);
		check(24'(i_mem.mem[a]), 24'(d[7:0]));
		check(24'(i_mem.mem[{a[23:16], a[15:0] + 16'h0001}]), 24'(d[15:8]));
	endtask
	task automatic t_reg;
		preset(SEL_SP, 16'he964);
		exec({OPC_PREFIX, OPC_IY_FROM_SP, 16'h0000}, 2);
		check(24'(SECOND_INDEX_REG), 24'h00e964);
		for (int r = 0; r < 4; r++) begin
			preset(4'(r), 16'h1000 + 16'(r));
			exec({OPC_PREFIX, OPC_SP_FROM_RP + 8'(r), 16'h0000}, 2);
			check(24'(STACK_TOP_POINTER), 24'h001000 + 24'(r));
		end
	endtask
	task automatic t_st;
		preset(SEL_EP, 16'h0012);
		preset(SEL_XP, 16'h0034);
		preset(SEL_YP, 16'h0056);
		preset(SEL_SP, 16'h1000);
		for (int r = 0; r < 4; r++) preset(4'(r), pv[r]);
		check(24'(EXPAND_PAGE_REG), 24'h000012);
		check(24'(FIRST_INDEX_PAGE_REG), 24'h000034);
		check(24'(SECOND_INDEX_PAGE_REG), 24'h000056);
		check(24'(PAIR_BA), 24'h00e964);
		check(24'(POINTER_PAIR), 24'h002000);
		check(24'(FIRST_INDEX_REG), 24'h003000);
		for (int r = 0; r < 4; r++) begin
			st({OPC_ST_ABS + 8'(r), 16'hffff, 8'h00}, 3, 5, 24'h12ffff, pv[r]);
			st({OPC_PREFIX, OPC_ST_HL + 8'(r), 16'h0}, 2, 5, 24'h122000, pv[r]);
			st({OPC_PREFIX, OPC_ST_IX + 8'(r), 16'h0}, 2, 5, 24'h343000, pv[r]);
			st({OPC_PREFIX, OPC_ST_IY + 8'(r), 16'h0}, 2, 5, 24'h564000, pv[r]);
			st({OPC_PREFIX, OPC_ST_SPD + 8'(r), r[0] ? 8'h80 : 8'h7f, 8'h00}, 3, 6,
				r[0] ? 24'h000f80 : 24'h00107f, pv[r]);
		end
		st({OPC_PREFIX, OPC_ST_SP_ABS, 16'h3412}, 4, 6, 24'h121234, 16'h1000);
	endtask
	task automatic t_misc;
		LARGE_MODEL = 1'b0;
		repeat (4) @(negedge CLOCK);
		st({OPC_ST_ABS, 16'h0050, 8'h00}, 3, 5, 24'h005000, pv[0]);
		LARGE_MODEL = 1'b1;
		exec({OPC_PREFIX, 8'h00, 16'h0000}, 2);
		check(24'({fin, ill}), 24'h000001);
		check(24'(SYSTEM_CONDITION_FLAGS), 24'h0000a5);
	endtask
	task automatic close_out;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog sized well above the roughly 350 clocks the tests need
	initial begin
		#400000;
		num_errors++;
		close_out;
	end
	initial begin
		repeat (6) @(negedge CLOCK);
		RST_N = 1'b1;
		preset(SEL_FLAGS, 16'h00a5);
		t_reg;
		t_st;
		t_misc;
		close_out;
	end
endmodule // tb_wide_register_load_store
